// ===== hw/tief_event_flags.v
// trace identifier event flags: change detection, read-to-clear apb registers, interrupt
`default_nettype none
`include "tief_map.vh"

module tief_event_flags (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // per slice mode and per group configuration (2 bits per group)
  input wire [2:0] tu3_mode,
  input wire [41:0] group_cfg,
  // condition levels, 7 bits per slice, bit g = group g+1
  input wire [20:0] mis_state_pos2,
  input wire [20:0] mis_state_pos3,
  input wire [20:0] mis_state_pos4,
  input wire [20:0] uns_state_pos1,
  input wire [20:0] uns_state_pos2,
  input wire [2:0] tu3_uns_state,
  // per tributary interrupt enables, same layout
  input wire [20:0] mis_irq_enable_pos2,
  input wire [20:0] mis_irq_enable_pos3,
  input wire [20:0] mis_irq_enable_pos4,
  input wire [20:0] unstable_irq_enable_pos1,
  input wire [20:0] unstable_irq_enable_pos2,
  // level interrupt per slice
  output reg [2:0] irq_slice
);

  genvar s;
  genvar r;
  integer k;

  // which groups are live for a register kind
  function [6:0] valid_mask;
    input integer kind;
    input [13:0] cfg;
    input tu3;
    integer g;
    reg [1:0] c;
    begin
      valid_mask = 7'h00;
      for (g = 0; g < `TIEF_NUM_GRP; g = g + 1) begin
        c = cfg[g*2 +: 2];
        case (kind)
          // position two needs vt3 or wider
          `TIEF_REG_MIS2, `TIEF_REG_UNS2: valid_mask[g] = ~tu3 && (c != `TIEF_CFG_TU2);
          // position three needs tu12 or tu11
          `TIEF_REG_MIS3: valid_mask[g] = ~tu3 && (c == `TIEF_CFG_TU12 || c == `TIEF_CFG_TU11);
          // position four needs tu11
          `TIEF_REG_MIS4: valid_mask[g] = ~tu3 && (c == `TIEF_CFG_TU11);
          // position one is always live
          `TIEF_REG_UNS1: valid_mask[g] = 1'b1;
          default: valid_mask[g] = 1'b0;
        endcase
      end
    end
  endfunction

  // word index to flat register number
  function [3:0] decode;
    input [10:0] idx;
    begin
      case (idx)
        `TIEF_IDX_MIS2_A: decode = `TIEF_BASE_A + `TIEF_REG_MIS2;
        `TIEF_IDX_MIS3_A: decode = `TIEF_BASE_A + `TIEF_REG_MIS3;
        `TIEF_IDX_MIS4_A: decode = `TIEF_BASE_A + `TIEF_REG_MIS4;
        `TIEF_IDX_UNS1_A: decode = `TIEF_BASE_A + `TIEF_REG_UNS1;
        `TIEF_IDX_UNS2_A: decode = `TIEF_BASE_A + `TIEF_REG_UNS2;
        `TIEF_IDX_MIS2_B: decode = `TIEF_BASE_B + `TIEF_REG_MIS2;
        `TIEF_IDX_MIS3_B: decode = `TIEF_BASE_B + `TIEF_REG_MIS3;
        `TIEF_IDX_MIS4_B: decode = `TIEF_BASE_B + `TIEF_REG_MIS4;
        `TIEF_IDX_UNS1_B: decode = `TIEF_BASE_B + `TIEF_REG_UNS1;
        `TIEF_IDX_UNS2_B: decode = `TIEF_BASE_B + `TIEF_REG_UNS2;
        `TIEF_IDX_MIS2_C: decode = `TIEF_BASE_C + `TIEF_REG_MIS2;
        `TIEF_IDX_MIS3_C: decode = `TIEF_BASE_C + `TIEF_REG_MIS3;
        `TIEF_IDX_MIS4_C: decode = `TIEF_BASE_C + `TIEF_REG_MIS4;
        `TIEF_IDX_UNS1_C: decode = `TIEF_BASE_C + `TIEF_REG_UNS1;
        `TIEF_IDX_UNS2_C: decode = `TIEF_BASE_C + `TIEF_REG_UNS2;
        default: decode = `TIEF_NO_REG;
      endcase
    end
  endfunction

  // flat views: register k occupies bits k*7 +: 7
  wire [104:0] cur_w;
  wire [104:0] mask_w;
  wire [104:0] en_w;
  wire [2:0] irq_nxt;

  reg [104:0] mismatch_event_flag_r;
  reg [104:0] prev_r;
  reg armed_r;
  reg [2:0] ctrl_r;

  reg [104:0] set_w;
  reg [104:0] clr_w;
  reg [104:0] flag_nxt;
  reg [31:0] rd_val;

  // apb decode
  wire word_ok = (paddr[1:0] == 2'h0);
  wire [3:0] reg_sel = word_ok ? decode(paddr[12:2]) : `TIEF_NO_REG;
  wire flag_hit = (reg_sel != `TIEF_NO_REG);
  wire ctrl_hit = word_ok && (paddr[12:2] == `TIEF_IDX_IRQ_CTRL);
  wire setup_rd = psel && !penable && !pwrite;
  wire access = psel && penable;
  wire rd_done = access && !pwrite && flag_hit;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !flag_hit && !ctrl_hit;

  // per slice wiring of condition levels, masks and enables
  generate
    for (s = 0; s < `TIEF_NUM_SLICE; s = s + 1) begin : g_slice
      assign cur_w[(s*5+`TIEF_REG_MIS2)*7 +: 7] = mis_state_pos2[s*7 +: 7];
      assign cur_w[(s*5+`TIEF_REG_MIS3)*7 +: 7] = mis_state_pos3[s*7 +: 7];
      assign cur_w[(s*5+`TIEF_REG_MIS4)*7 +: 7] = mis_state_pos4[s*7 +: 7];
      // bit 0 follows the tu3 identifier in tu3 mode
      assign cur_w[(s*5+`TIEF_REG_UNS1)*7 +: 7] =
        {uns_state_pos1[s*7+1 +: 6], tu3_mode[s] ? tu3_uns_state[s] : uns_state_pos1[s*7]};
      assign cur_w[(s*5+`TIEF_REG_UNS2)*7 +: 7] = uns_state_pos2[s*7 +: 7];

      assign en_w[(s*5+`TIEF_REG_MIS2)*7 +: 7] = mis_irq_enable_pos2[s*7 +: 7];
      assign en_w[(s*5+`TIEF_REG_MIS3)*7 +: 7] = mis_irq_enable_pos3[s*7 +: 7];
      assign en_w[(s*5+`TIEF_REG_MIS4)*7 +: 7] = mis_irq_enable_pos4[s*7 +: 7];
      assign en_w[(s*5+`TIEF_REG_UNS1)*7 +: 7] = unstable_irq_enable_pos1[s*7 +: 7];
      assign en_w[(s*5+`TIEF_REG_UNS2)*7 +: 7] = unstable_irq_enable_pos2[s*7 +: 7];

      for (r = 0; r < `TIEF_REG_PER; r = r + 1) begin : g_reg
        assign mask_w[(s*5+r)*7 +: 7] = valid_mask(r, group_cfg[s*14 +: 14], tu3_mode[s]);
      end

      // enables gate only the interrupt, never the flag
      assign irq_nxt[s] = ctrl_r[s] &&
        (|(mismatch_event_flag_r[s*35 +: 35] & mask_w[s*35 +: 35] & en_w[s*35 +: 35]));
    end
  endgenerate

  // change detection and read-to-clear
  always @* begin
    set_w = 105'h0;
    clr_w = 105'h0;
    // once armed, any change of level on a live tributary is an event, in either direction
    if (armed_r) begin
      set_w = (cur_w ^ prev_r) & mask_w;
    end
    // clear only the bits the reader was shown
    if (rd_done) begin
      clr_w[reg_sel*7 +: 7] = prdata[6:0];
    end
    // a set in the clearing cycle survives
    flag_nxt = (mismatch_event_flag_r & ~clr_w) | set_w;
  end

  // read mux; inactive tributaries and bit 7 read zero
  always @* begin
    rd_val = 32'h0;
    if (flag_hit) begin
      rd_val[6:0] = mismatch_event_flag_r[reg_sel*7 +: 7] & mask_w[reg_sel*7 +: 7];
    end else if (ctrl_hit) begin
      rd_val[2:0] = ctrl_r;
    end
  end

  // flag, edge reference and arming state
  // arming skips the first cycle so reset-time levels raise no event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_event_flag_r <= 105'h0;
      prev_r <= 105'h0;
      armed_r <= 1'b0;
    end else begin
      mismatch_event_flag_r <= flag_nxt;
      prev_r <= cur_w;
      armed_r <= 1'b1;
    end
  end

  // read data is caught in the setup cycle and held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_rd) begin
      prdata <= rd_val;
    end
  end

  // slice interrupt gating register, byte lane 0
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TIEF_CTRL_RST;
    end else if (access && pwrite && ctrl_hit && pstrb[0]) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  // interrupt drops the second cycle after the clearing read, one cycle after the flag clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_slice <= 3'h0;
    end else begin
      irq_slice <= irq_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== hw/tief_map.vh
// register map and constants for the trace identifier event flag block
`ifndef TIEF_MAP_VH
`define TIEF_MAP_VH

// geometry
`define TIEF_NUM_SLICE 3
`define TIEF_NUM_GRP 7
`define TIEF_REG_PER 5
`define TIEF_FLAG_W 7
`define TIEF_ALL_W 105
`define TIEF_SLICE_W 35

// register kind inside a slice
`define TIEF_REG_MIS2 4'h0
`define TIEF_REG_MIS3 4'h1
`define TIEF_REG_MIS4 4'h2
`define TIEF_REG_UNS1 4'h3
`define TIEF_REG_UNS2 4'h4

// flat register number = slice base + kind
`define TIEF_BASE_A 4'h0
`define TIEF_BASE_B 4'h5
`define TIEF_BASE_C 4'ha
`define TIEF_NO_REG 4'hf

// group configuration codes
`define TIEF_CFG_TU2 2'h0
`define TIEF_CFG_VT3 2'h1
`define TIEF_CFG_TU12 2'h2
`define TIEF_CFG_TU11 2'h3

// register indices; byte address is four times the index
`define TIEF_IDX_MIS2_A 11'h421
`define TIEF_IDX_MIS3_A 11'h422
`define TIEF_IDX_MIS4_A 11'h423
`define TIEF_IDX_UNS1_A 11'h424
`define TIEF_IDX_UNS2_A 11'h425
`define TIEF_IDX_MIS2_B 11'h461
`define TIEF_IDX_MIS3_B 11'h462
`define TIEF_IDX_MIS4_B 11'h463
`define TIEF_IDX_UNS1_B 11'h464
`define TIEF_IDX_UNS2_B 11'h465
`define TIEF_IDX_MIS2_C 11'h4a1
`define TIEF_IDX_MIS3_C 11'h4a2
`define TIEF_IDX_MIS4_C 11'h4a3
`define TIEF_IDX_UNS1_C 11'h4a4
`define TIEF_IDX_UNS2_C 11'h4a5
`define TIEF_IDX_IRQ_CTRL 11'h4c0

// irq gating register: one bit per slice
`define TIEF_CTRL_W 3
`define TIEF_CTRL_RST 3'h7

`endif

// ===== test/tief_asserts.sv
// checker for the trace identifier event flag block
`default_nettype none
module tief_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] tu3_mode,
  input wire [41:0] group_cfg,
  input wire [20:0] mis_irq_enable_pos2,
  input wire [20:0] mis_irq_enable_pos3,
  input wire [20:0] mis_irq_enable_pos4,
  input wire [20:0] unstable_irq_enable_pos1,
  input wire [20:0] unstable_irq_enable_pos2,
  input wire [2:0] irq_slice
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup cycle, slice a group one config and any slice a enable
  wire rd = psel && !penable && !pwrite;
  wire [1:0] ca = group_cfg[1:0];
  wire en_a = |{mis_irq_enable_pos2[6:0], mis_irq_enable_pos3[6:0], mis_irq_enable_pos4[6:0],
    unstable_irq_enable_pos1[6:0], unstable_irq_enable_pos2[6:0]};
  property p_hi; rd |=> prdata[31:7] == 25'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_tu3; rd && tu3_mode[0] && paddr inside {13'h1084, 13'h1088, 13'h108c, 13'h1094} |=> prdata == 0; endproperty
  a_tu3: assert property (p_tu3) else $error("flag in single unit mode");
  property p_p2; rd && paddr == 13'h1084 && ca == 2'h0 |=> !prdata[0]; endproperty
  a_p2: assert property (p_p2) else $error("inactive pos2 mismatch flag");
  property p_u2; rd && paddr == 13'h1094 && ca == 2'h0 |=> !prdata[0]; endproperty
  a_u2: assert property (p_u2) else $error("inactive pos2 unstable flag");
  property p_p3; rd && paddr == 13'h1088 && ca < 2'h2 |=> !prdata[0]; endproperty
  a_p3: assert property (p_p3) else $error("inactive pos3 mismatch flag");
  property p_p4; rd && paddr == 13'h108c && ca != 2'h3 |=> !prdata[0]; endproperty
  a_p4: assert property (p_p4) else $error("inactive pos4 mismatch flag");
  property p_msk; $past(!en_a) |-> !irq_slice[0]; endproperty
  a_msk: assert property (p_msk) else $error("interrupt with enables low");
  property p_hold; !rd |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_rd: cover property (rd);
  c_irq: cover property ($rose(irq_slice[0]));
  c_err: cover property (pslverr);
endmodule
bind tief_event_flags tief_asserts tief_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tu3_mode(tu3_mode), .group_cfg(group_cfg), .mis_irq_enable_pos2(mis_irq_enable_pos2),
  .mis_irq_enable_pos3(mis_irq_enable_pos3), .mis_irq_enable_pos4(mis_irq_enable_pos4),
  .unstable_irq_enable_pos1(unstable_irq_enable_pos1), .unstable_irq_enable_pos2(unstable_irq_enable_pos2),
  .irq_slice(irq_slice));
`default_nettype wire

// ===== test/tief_event_flags_bench.sv
// self-checking bench for the trace identifier event flag block
`default_nettype none
module tief_event_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] tm, tu3u, tu3x, irq;
  logic [41:0] cfg;
  logic [20:0] st [5];
  logic [20:0] en [5];
  logic [20:0] rr [5];
  logic [32:0] expq [$];
  int error_cnt = 0, comparisons = 0, cyc = 0;
  tief_event_flags tief_event_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tu3_mode(tm), .group_cfg(cfg), .mis_state_pos2(st[0]), .mis_state_pos3(st[1]),
    .mis_state_pos4(st[2]), .uns_state_pos1(st[3]), .uns_state_pos2(st[4]), .tu3_uns_state(tu3u),
    .mis_irq_enable_pos2(en[0]), .mis_irq_enable_pos3(en[1]), .mis_irq_enable_pos4(en[2]),
    .unstable_irq_enable_pos1(en[3]), .unstable_irq_enable_pos2(en[4]), .irq_slice(irq));
  // 50 mhz clock
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, run needs well under this
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // completed reads are judged against the oldest note
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) chk("prdata", expq.pop_front(), {pslverr, prdata});
  // one apb transfer; idle edge after it so the next call never overlaps
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [12:0] addr_of(input int s, input int k);
    return 13'(4 * ((s == 0 ? 'h421 : s == 1 ? 'h461 : 'h4a1) + k));
  endfunction
  // expected flags from toggles, group config and single unit mode
  function automatic logic [6:0] expv(input int s, input int k);
    logic [6:0] v;
    logic [1:0] c;
    v = rr[k][s * 7 +: 7];
    for (int g = 0; g < 7; g++) begin
      c = cfg[s * 14 + g * 2 +: 2];
      if ((k % 4 == 0 && c == 0) || (k == 1 && c < 2) || (k == 2 && c != 3)) v[g] = 0;
    end
    if (tm[s]) v = (k == 3) ? {v[6:1], tu3x[s]} : 7'h0;
    return v;
  endfunction
  task automatic scan();
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 5; k++) apb(1'b0, addr_of(s, k), 32'h0, {26'h0, expv(s, k)});
  endtask
  // back toggles every raised level, so rounds start and end at zero
  task automatic toggle(input bit back);
    for (int k = 0; k < 5; k++) begin
      rr[k] = back ? st[k] : 21'($urandom);
      st[k] <= st[k] ^ rr[k];
    end
    tu3x = back ? tu3u : 3'($urandom);
    tu3u <= tu3u ^ tu3x;
    repeat (3) @(posedge pclk);
    chk("irq_slice", 33'h0, {30'h0, irq});
  endtask
  task automatic round();
    toggle(0);
    scan();
    toggle(1);
    scan();
    rr = '{default: 21'h0};
    tu3x = 3'h0;
    scan();
  endtask
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    presetn = 0;
    cfg = '1;
    tm = 0;
    tu3u = 0;
    tu3x = 0;
    st = '{default: 21'h0};
    en = st;
    rr = st;
    void'($urandom(32'h09d356a8));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    scan();
    apb(1'b0, 13'h0004, 32'h0, 33'h100000000);
    apb(1'b1, addr_of(0, 0), 32'hff, 33'h0);
    round();
    for (int i = 0; i < 4; i++) begin
      cfg <= {10'($urandom), 30'($urandom), 2'(i)};
      tm <= 3'(i);
      @(posedge pclk);
      round();
    end
    // interrupt raised, cleared by read, then gated but still latched
    cfg <= '1;
    tm <= 3'h0;
    en <= '{default: 21'h1fffff};
    st[1] <= 21'h1;
    repeat (3) @(posedge pclk);
    chk("irq_slice", 33'h1, {30'h0, irq});
    apb(1'b0, addr_of(0, 1), 32'h0, 33'h1);
    @(posedge pclk);
    chk("irq_slice", 33'h0, {30'h0, irq});
    apb(1'b1, 13'h1300, 32'h0, 33'h0);
    apb(1'b0, 13'h1300, 32'h0, 33'h0);
    st[1] <= 21'h0;
    repeat (3) @(posedge pclk);
    chk("irq_slice", 33'h0, {30'h0, irq});
    apb(1'b0, addr_of(0, 1), 32'h0, 33'h1);
    // event landing inside a read survives it
    st[2] <= 21'h1;
    apb(1'b0, addr_of(0, 2), 32'h0, 33'h0);
    apb(1'b0, addr_of(0, 2), 32'h0, 33'h1);
    complete_run();
  end
endmodule
`default_nettype wire
